// >>> itfd_pkg.sv
// Purpose: shared constants and state types for the input terminal function decoder
// Assumes: five multi-function inputs, six-bit function codes, 0.1 % command units
// Notes:   every code, width and reset value used by more than one file sits here
package itfd_pkg;

    localparam int          NUM_TERM      = 5;        // multi-function inputs
    localparam int          CODE_W        = 6;        // width of one function code
    localparam int          STEP_NUM      = 16;       // stored multi-step commands
    localparam int          STEP_W        = 16;       // width of one stored command
    localparam int          FREQ_W        = 16;       // frequency word width
    localparam int          IDX_W         = 4;        // multi-step index width

    // function codes seen by this block
    localparam logic [5:0]  FN_SPD_SEL0   = 6'h0C;    // speed select terminal 1
    localparam logic [5:0]  FN_SPD_SEL1   = 6'h0D;    // speed select terminal 2
    localparam logic [5:0]  FN_SPD_SEL2   = 6'h0E;    // speed select terminal 3
    localparam logic [5:0]  FN_SPD_SEL3   = 6'h0F;    // speed select terminal 4
    localparam logic [5:0]  FN_PID_REV    = 6'h23;    // pid direction reversal
    localparam logic [5:0]  FN_EXT_STOP1  = 6'h24;    // keypad-equivalent stop
    localparam logic [5:0]  FN_SRC_SWAP   = 6'h25;    // terminal/comm swap
    localparam logic [5:0]  FN_PID_IHOLD  = 6'h26;    // integral pause
    localparam logic [5:0]  FN_FX_KEYPAD  = 6'h27;    // source x to keypad freq
    localparam logic [5:0]  FN_FY_KEYPAD  = 6'h28;    // source y to keypad freq
    localparam logic [5:0]  FN_PID_GAIN   = 6'h2B;    // pid gain set swap
    localparam logic [5:0]  FN_MODE_SWAP  = 6'h2E;    // speed/torque swap
    localparam logic [5:0]  FN_ESTOP      = 6'h2F;    // emergency stop
    localparam logic [5:0]  FN_EXT_STOP2  = 6'h30;    // decel stop, time 4
    localparam logic [5:0]  FN_DEC_DCBRK  = 6'h31;    // decel then dc brake
    localparam logic [5:0]  FN_TMR_CLR    = 6'h32;    // clear current run time

    // command sources
    localparam logic [1:0]  SRC_KEYPAD    = 2'h0;
    localparam logic [1:0]  SRC_TERMINAL  = 2'h1;
    localparam logic [1:0]  SRC_COMM      = 2'h2;

    localparam logic [1:0]  DECEL_SEL_4   = 2'h3;     // fourth decel time setting
    localparam logic [1:0]  DECEL_SEL_RST = 2'h0;     // first decel time setting
    localparam logic [31:0] FULL_SCALE    = 32'h0000_03E8; // 100.0 % in 0.1 % steps
    localparam logic [3:0]  IDX_RST       = 4'h0;     // index after reset

    // true when any terminal assigned exactly this code is valid
    function automatic logic itfd_code_active(
        input logic [NUM_TERM-1:0]        states,
        input logic [NUM_TERM*CODE_W-1:0] codes,
        input logic [CODE_W-1:0]          code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_TERM; i++) begin
            if (states[i] && (codes[i*CODE_W +: CODE_W] == code)) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    typedef struct packed {
        logic [IDX_W-1:0] idx;                       // sampled speed index
    } itfd_sel_state_t;

    typedef struct packed {
        logic              pid_dir_invert;
        logic              keypad_stop;
        logic              pid_int_hold;
        logic              fx_use_keypad;
        logic              fy_use_keypad;
        logic              pid_gain_set2;
        logic              torque_mode;
        logic              estop;
        logic [15:0]       estop_current;
        logic              stop_decel;
        logic [1:0]        decel_sel;
        logic              decel_dc_req;
        logic              dc_brake;
        logic              run_timer_clr;
        logic [1:0]        cmd_src;
        logic [IDX_W-1:0]  step_idx;
        logic [STEP_W-1:0] step_cmd;
        logic [FREQ_W-1:0] step_freq;
    } itfd_state_t;

endpackage

// >>> itfd_speed_sel.sv
// Purpose: samples the four speed select terminals into a 4-bit index
// Assumes: terminal states are synchronous and already filtered
// Notes:   index is registered so a change shows one cycle later
`timescale 1ns/10ps
module itfd_speed_sel (
    input  wire logic                                      clk,
    input  wire logic                                      reset_n,
    input  wire logic [itfd_pkg::NUM_TERM-1:0]             term_state,
    input  wire logic [itfd_pkg::NUM_TERM*itfd_pkg::CODE_W-1:0] term_code,
    output logic      [itfd_pkg::IDX_W-1:0]                speed_idx
);

    itfd_pkg::itfd_sel_state_t st_r;    // registered state
    itfd_pkg::itfd_sel_state_t st_nxt;  // next state
    logic                      speed_select_bit0;
    logic                      speed_select_bit1;
    logic                      speed_select_bit2;
    logic                      speed_select_bit3;

    // each select bit may come from any terminal carrying its code
    always_comb begin
        speed_select_bit0 = itfd_pkg::itfd_code_active(term_state, term_code, itfd_pkg::FN_SPD_SEL0);
        speed_select_bit1 = itfd_pkg::itfd_code_active(term_state, term_code, itfd_pkg::FN_SPD_SEL1);
        speed_select_bit2 = itfd_pkg::itfd_code_active(term_state, term_code, itfd_pkg::FN_SPD_SEL2);
        speed_select_bit3 = itfd_pkg::itfd_code_active(term_state, term_code, itfd_pkg::FN_SPD_SEL3);
        st_nxt     = st_r;
        // fourth terminal is the msb, first the lsb
        st_nxt.idx = {speed_select_bit3, speed_select_bit2, speed_select_bit1, speed_select_bit0};
    end

    // sampled every cycle, no hold
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r.idx <= itfd_pkg::IDX_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign speed_idx = st_r.idx;

    AST_IDX_NEXT: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> (speed_idx == $past({speed_select_bit3, speed_select_bit2, speed_select_bit1, speed_select_bit0})))
        else $error("speed index did not follow select terminals");

    AST_IDX_ALL_ON: assert property (@(posedge clk) disable iff (!reset_n)
        (speed_select_bit0 && speed_select_bit1 && speed_select_bit2 && speed_select_bit3)
        |=> (speed_idx == 4'hF))
        else $error("all selects active did not give index 15");

endmodule

// >>> itfd_top.sv
// Purpose: turns multi-function input terminal states into drive control levels
// Assumes: terminal states filtered and synchronous; codes stable while used
// Notes:   all outputs registered, so each action lags its terminal by one cycle and the step outputs by two
`timescale 1ns/10ps
module itfd_top (
    input  wire logic                                            clk,
    input  wire logic                                            reset_n,
    input  wire logic [itfd_pkg::NUM_TERM-1:0]                   multi_function_input,
    input  wire logic [itfd_pkg::NUM_TERM*itfd_pkg::CODE_W-1:0]  term_code,
    input  wire logic [1:0]                                      cfg_cmd_src,
    input  wire logic                                            cfg_torque_mode,
    input  wire logic                                            cfg_pid_gain_by_term,
    input  wire logic [15:0]                                     cfg_current_limit,
    input  wire logic [itfd_pkg::FREQ_W-1:0]                     cfg_max_freq,
    input  wire logic [itfd_pkg::FREQ_W-1:0]                     cfg_dc_start_freq,
    input  wire logic [itfd_pkg::FREQ_W-1:0]                     out_freq,
    input  wire logic [itfd_pkg::STEP_NUM*itfd_pkg::STEP_W-1:0]  step_table,
    output logic                                                 pid_dir_invert,
    output logic                                                 keypad_stop,
    output logic                                                 pid_int_hold,
    output logic                                                 fx_use_keypad,
    output logic                                                 fy_use_keypad,
    output logic                                                 pid_gain_set2,
    output logic                                                 torque_mode,
    output logic                                                 estop,
    output logic      [15:0]                                     estop_current,
    output logic                                                 stop_decel,
    output logic      [1:0]                                      decel_sel,
    output logic                                                 decel_dc_req,
    output logic                                                 dc_brake,
    output logic                                                 run_timer_clr,
    output logic      [1:0]                                      cmd_src,
    output logic      [itfd_pkg::IDX_W-1:0]                      step_idx,
    output logic      [itfd_pkg::STEP_W-1:0]                     step_cmd,
    output logic      [itfd_pkg::FREQ_W-1:0]                     step_freq
);

    itfd_pkg::itfd_state_t   st_r;        // registered state
    itfd_pkg::itfd_state_t   st_nxt;      // next state
    logic [itfd_pkg::IDX_W-1:0] sel_idx;  // index from selector
    logic                    act_pid_rev;  // decoded terminal levels
    logic                    act_stop1;
    logic                    act_swap;
    logic                    act_ihold;
    logic                    act_fx;
    logic                    act_fy;
    logic                    act_gain;
    logic                    act_mode;
    logic                    act_estop;
    logic                    act_stop2;
    logic                    act_decdc;
    logic                    act_tmr;
    logic [31:0]             scaled;       // command times max frequency

    // speed index sampling lives in its own small module
    itfd_speed_sel u_sel (
        .clk        (clk),
        .reset_n    (reset_n),
        .term_state (multi_function_input),
        .term_code  (term_code),
        .speed_idx  (sel_idx)
    );

    // decode each code; unknown or reserved codes never match any of these
    always_comb begin
        act_pid_rev = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_PID_REV);
        act_stop1   = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_EXT_STOP1);
        act_swap    = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_SRC_SWAP);
        act_ihold   = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_PID_IHOLD);
        act_fx      = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_FX_KEYPAD);
        act_fy      = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_FY_KEYPAD);
        act_gain    = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_PID_GAIN);
        act_mode    = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_MODE_SWAP);
        act_estop   = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_ESTOP);
        act_stop2   = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_EXT_STOP2);
        act_decdc   = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_DEC_DCBRK);
        act_tmr     = itfd_pkg::itfd_code_active(multi_function_input, term_code, itfd_pkg::FN_TMR_CLR);
    end

    // next-state logic for every control level
    always_comb begin
        st_nxt = st_r;
        scaled = 32'h0000_0000;

        // pid controls
        st_nxt.pid_dir_invert = act_pid_rev;
        st_nxt.pid_int_hold   = act_ihold;
        // gain swap honoured only when the switch condition names terminals
        st_nxt.pid_gain_set2  = cfg_pid_gain_by_term && act_gain;

        // frequency source substitution
        st_nxt.fx_use_keypad  = act_fx;
        st_nxt.fy_use_keypad  = act_fy;

        // speed/torque swap is relative to the configured mode
        st_nxt.torque_mode    = cfg_torque_mode ^ act_mode;

        // command source: swap is a level, keypad source is left alone
        case (cfg_cmd_src)
            itfd_pkg::SRC_TERMINAL: begin
                st_nxt.cmd_src = act_swap ? itfd_pkg::SRC_COMM : itfd_pkg::SRC_TERMINAL;
            end
            itfd_pkg::SRC_COMM: begin
                st_nxt.cmd_src = act_swap ? itfd_pkg::SRC_TERMINAL : itfd_pkg::SRC_COMM;
            end
            itfd_pkg::SRC_KEYPAD: begin
                st_nxt.cmd_src = itfd_pkg::SRC_KEYPAD;
            end
            default: begin
                // unused encoding falls back to keypad control
                st_nxt.cmd_src = itfd_pkg::SRC_KEYPAD;
            end
        endcase

        // keypad-equivalent stop acts only while keypad has command
        st_nxt.keypad_stop = act_stop1 && (st_nxt.cmd_src == itfd_pkg::SRC_KEYPAD);

        // emergency stop holds output current at the configured ceiling
        st_nxt.estop         = act_estop;
        st_nxt.estop_current = act_estop ? cfg_current_limit : 16'h0000;

        // external stop 2 works under any source, always decel time four
        st_nxt.stop_decel = act_stop2;
        st_nxt.decel_sel  = act_stop2 ? itfd_pkg::DECEL_SEL_4 : itfd_pkg::DECEL_SEL_RST;

        // decel to dc start frequency, then brake
        st_nxt.decel_dc_req = act_decdc;
        st_nxt.dc_brake     = act_decdc && (out_freq <= cfg_dc_start_freq);

        // run timer clear is a level held while the terminal is valid
        st_nxt.run_timer_clr = act_tmr;

        // step command picked by the index from the selector
        st_nxt.step_idx = sel_idx;
        st_nxt.step_cmd = step_table[sel_idx*itfd_pkg::STEP_W +: itfd_pkg::STEP_W];
        // 1000 counts = max frequency; values above full scale are clamped
        if ({16'h0000, st_nxt.step_cmd} >= itfd_pkg::FULL_SCALE) begin
            st_nxt.step_freq = cfg_max_freq;
        end else begin
            scaled           = {16'h0000, st_nxt.step_cmd} * {16'h0000, cfg_max_freq};
            st_nxt.step_freq = 16'((scaled / itfd_pkg::FULL_SCALE));
        end
    end

    // single register bank for the whole state
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r.pid_dir_invert <= 1'b0;
            st_r.keypad_stop    <= 1'b0;
            st_r.pid_int_hold   <= 1'b0;
            st_r.fx_use_keypad  <= 1'b0;
            st_r.fy_use_keypad  <= 1'b0;
            st_r.pid_gain_set2  <= 1'b0;
            st_r.torque_mode    <= 1'b0;
            st_r.estop          <= 1'b0;
            st_r.estop_current  <= 16'h0000;
            st_r.stop_decel     <= 1'b0;
            st_r.decel_sel      <= itfd_pkg::DECEL_SEL_RST;
            st_r.decel_dc_req   <= 1'b0;
            st_r.dc_brake       <= 1'b0;
            st_r.run_timer_clr  <= 1'b0;
            st_r.cmd_src        <= itfd_pkg::SRC_KEYPAD;
            st_r.step_idx       <= itfd_pkg::IDX_RST;
            st_r.step_cmd       <= 16'h0000;
            st_r.step_freq      <= 16'h0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the register bank
    assign pid_dir_invert = st_r.pid_dir_invert;
    assign keypad_stop    = st_r.keypad_stop;
    assign pid_int_hold   = st_r.pid_int_hold;
    assign fx_use_keypad  = st_r.fx_use_keypad;
    assign fy_use_keypad  = st_r.fy_use_keypad;
    assign pid_gain_set2  = st_r.pid_gain_set2;
    assign torque_mode    = st_r.torque_mode;
    assign estop          = st_r.estop;
    assign estop_current  = st_r.estop_current;
    assign stop_decel     = st_r.stop_decel;
    assign decel_sel      = st_r.decel_sel;
    assign decel_dc_req   = st_r.decel_dc_req;
    assign dc_brake       = st_r.dc_brake;
    assign run_timer_clr  = st_r.run_timer_clr;
    assign cmd_src        = st_r.cmd_src;
    assign step_idx       = st_r.step_idx;
    assign step_cmd       = st_r.step_cmd;
    assign step_freq      = st_r.step_freq;

    AST_PID_INV: assert property (@(posedge clk) disable iff (!reset_n)
        act_pid_rev |=> pid_dir_invert)
        else $error("pid direction not inverted");

    AST_KEYPAD_STOP: assert property (@(posedge clk) disable iff (!reset_n)
        (act_stop1 && cfg_cmd_src == itfd_pkg::SRC_TERMINAL) |=> !keypad_stop)
        else $error("stop 1 acted outside keypad control");

    AST_SRC_SWAP: assert property (@(posedge clk) disable iff (!reset_n)
        (act_swap && cfg_cmd_src == itfd_pkg::SRC_TERMINAL) |=> (cmd_src == itfd_pkg::SRC_COMM))
        else $error("source swap did not select comm");

    AST_IHOLD: assert property (@(posedge clk) disable iff (!reset_n)
        (act_ihold && !act_pid_rev) |=> (pid_int_hold && !pid_dir_invert))
        else $error("integral hold disturbed other pid action");

    AST_FX_FY: assert property (@(posedge clk) disable iff (!reset_n)
        (act_fx && !act_fy) |=> (fx_use_keypad && !fy_use_keypad))
        else $error("source x substitution wrong");

    AST_GAIN: assert property (@(posedge clk) disable iff (!reset_n)
        !cfg_pid_gain_by_term |=> !pid_gain_set2)
        else $error("gain set 2 chosen without terminal condition");

    AST_MODE: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> (torque_mode == ($past(cfg_torque_mode) ^ $past(act_mode))))
        else $error("speed/torque mode wrong");

    AST_ESTOP: assert property (@(posedge clk) disable iff (!reset_n)
        act_estop |=> (estop && estop_current == $past(cfg_current_limit)))
        else $error("emergency stop current not at limit");

    AST_STOP2: assert property (@(posedge clk) disable iff (!reset_n)
        act_stop2 |=> (stop_decel && decel_sel == itfd_pkg::DECEL_SEL_4))
        else $error("stop 2 not using fourth decel time");

    AST_DCBRK: assert property (@(posedge clk) disable iff (!reset_n)
        dc_brake |-> decel_dc_req)
        else $error("dc braking without decel request");

    AST_TMR: assert property (@(posedge clk) disable iff (!reset_n)
        act_tmr |=> run_timer_clr)
        else $error("run timer not cleared");

    AST_FULL_SCALE: assert property (@(posedge clk) disable iff (!reset_n)
        ({16'h0000, st_nxt.step_cmd} >= itfd_pkg::FULL_SCALE) |=> (step_freq == $past(cfg_max_freq)))
        else $error("full scale command not at max frequency");

    AST_STEP_PICK: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> (step_cmd == $past(step_table[sel_idx*itfd_pkg::STEP_W +: itfd_pkg::STEP_W])))
        else $error("step command not from selected entry");

    // the checks below look one edge past the decode, matching the registered outputs
    AST_KEYPAD_ACT: assert property (@(posedge clk) disable iff (!reset_n)
        (act_stop1 && cfg_cmd_src == itfd_pkg::SRC_KEYPAD) |=> keypad_stop)
        else $error("stop 1 ignored under keypad control");

    AST_KEYPAD_SRC: assert property (@(posedge clk) disable iff (!reset_n)
        (cfg_cmd_src == itfd_pkg::SRC_KEYPAD) |=> (cmd_src == itfd_pkg::SRC_KEYPAD))
        else $error("keypad source moved by swap terminal");

    AST_FY: assert property (@(posedge clk) disable iff (!reset_n)
        (act_fy && !act_fx) |=> (fy_use_keypad && !fx_use_keypad))
        else $error("source y substitution wrong");

    AST_GAIN_ON: assert property (@(posedge clk) disable iff (!reset_n)
        (cfg_pid_gain_by_term && act_gain) |=> pid_gain_set2)
        else $error("gain set 2 not chosen by terminal");

    AST_ESTOP_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        !act_estop |=> (!estop && estop_current == 16'h0000))
        else $error("emergency stop without terminal");

    AST_STOP2_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        !act_stop2 |=> (!stop_decel && decel_sel == itfd_pkg::DECEL_SEL_RST))
        else $error("stop 2 active without terminal");

    // braking must wait while the output is still above the start frequency
    AST_DCBRK_WAIT: assert property (@(posedge clk) disable iff (!reset_n)
        (act_decdc && out_freq > cfg_dc_start_freq) |=> (decel_dc_req && !dc_brake))
        else $error("dc braking before start frequency");

    AST_TMR_OFF: assert property (@(posedge clk) disable iff (!reset_n)
        !act_tmr |=> !run_timer_clr)
        else $error("run timer cleared without terminal");

    AST_STEP_SCALE: assert property (@(posedge clk) disable iff (!reset_n)
        ({16'h0000, st_nxt.step_cmd} < itfd_pkg::FULL_SCALE) |=> (step_freq <= $past(cfg_max_freq)))
        else $error("step frequency above max frequency");

    // a terminal on a reserved or unlisted code must leave every action low except torque_mode, which follows its configured mode
    AST_QUIET: assert property (@(posedge clk) disable iff (!reset_n)
        !(act_pid_rev || act_stop1 || act_ihold || act_fx || act_fy || act_gain || act_estop
          || act_stop2 || act_decdc || act_tmr)
        |=> !(pid_dir_invert || keypad_stop || pid_int_hold || fx_use_keypad || fy_use_keypad
              || pid_gain_set2 || estop || stop_decel || decel_dc_req || dc_brake || run_timer_clr))
        else $error("action raised with no listed code valid");

endmodule

// >>> itfd_term_model.sv
// Purpose: switch bank model that drives the five input terminals
// Assumes: caller updates it just after a rising clock edge
// Notes:   terminals are levels, so a state holds until it is changed
`timescale 1ns/10ps
module itfd_term_model (
    output logic [4:0]  multi_function_input, // terminal levels, 1 = valid
    output logic [29:0] term_code             // six-bit code per terminal
);
    // all switches open and unassigned at power up
    initial begin
        multi_function_input = 5'h00;
        term_code            = 30'h0000_0000;
    end
    // assign a code and a level to one terminal; non-blocking so a
    // call made at a rising edge never races the decoder sampling it
    task automatic set_term(input int i, input logic [5:0] code, input logic st);
        term_code[i*6 +: 6]     <= code;
        multi_function_input[i] <= st;
    endtask
endmodule

// >>> itfd_tb.sv
// Purpose: self-checking bench for the input terminal function decoder
// Assumes: outputs settle two edges after a terminal change
// Notes:   terminals 0..3 hold the speed selects until terminal 3 takes other codes in the last tests, terminal 4 sweeps codes
`timescale 1ns/10ps
module tb;
    logic         clk;       // control clock
    logic         reset_n;   // active low reset
    wire  [4:0]   mfi;       // terminal levels
    wire  [29:0]  codes;     // terminal codes
    logic [1:0]   src;       // configured source
    logic         tq;        // configured torque mode
    logic [255:0] tbl;       // stored step commands
    wire  [11:0]  bits;      // gathered single-bit actions
    wire  [15:0]  cur;       // stop current
    wire  [15:0]  sc;        // step command
    wire  [15:0]  sf;        // step frequency
    wire  [1:0]   dsel;      // decel select
    wire  [1:0]   csrc;      // effective source
    wire  [3:0]   sidx;      // step index
    int           bad_count; // mismatches
    int           tests_run; // comparisons
    logic [15:0]  e;         // expected step value
    logic         gbt;       // gain switch condition names terminals
    logic [15:0]  ofreq;     // present output frequency

    itfd_term_model sw (.multi_function_input(mfi), .term_code(codes));
    itfd_top dut (.clk(clk), .reset_n(reset_n), .multi_function_input(mfi), .term_code(codes),
        .cfg_cmd_src(src), .cfg_torque_mode(tq), .cfg_pid_gain_by_term(gbt),
        .cfg_current_limit(16'h0123), .cfg_max_freq(16'h1388), .cfg_dc_start_freq(16'h0100),
        .out_freq(ofreq), .step_table(tbl), .pid_dir_invert(bits[11]), .keypad_stop(bits[10]),
        .pid_int_hold(bits[9]), .fx_use_keypad(bits[8]), .fy_use_keypad(bits[7]),
        .pid_gain_set2(bits[6]), .torque_mode(bits[5]), .estop(bits[4]), .estop_current(cur),
        .stop_decel(bits[3]), .decel_sel(dsel), .decel_dc_req(bits[2]), .dc_brake(bits[1]),
        .run_timer_clr(bits[0]), .cmd_src(csrc), .step_idx(sidx), .step_cmd(sc), .step_freq(sf));

    always #20 clk = ~clk;

    // expected action vector for one valid terminal on a given code
    function automatic logic [11:0] exp_bits(input int c);
        case (c)
            35: return 12'h800;
            36: return 12'h400;
            38: return 12'h200;
            39: return 12'h100;
            40: return 12'h080;
            43: return 12'h040;
            46: return 12'h020;
            47: return 12'h010;
            48: return 12'h008;
            49: return 12'h006; // out_freq sits below the brake start, so braking follows
            50: return 12'h001;
            default: return 12'h000; // reserved and unlisted codes stay quiet
        endcase
    endfunction

    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        clk       = 1'b0;
        reset_n   = 1'b0;
        src       = 2'h0;
        tq        = 1'b0;
        gbt       = 1'b1;
        ofreq     = 16'h0080;
        bad_count = 0;
        tests_run = 0;
        for (int k = 0; k < 16; k++) tbl[k*16 +: 16] = 16'(k * 70);
        step(4);
        reset_n <= 1'b1;
        step(1);
        for (int i = 0; i < 4; i++) sw.set_term(i, 6'h0C + 6'(i), 1'b0);
        // sweep every code from 34 to 51 on one terminal, valid then released
        for (int c = 34; c < 52; c++) begin
            sw.set_term(4, 6'(c), 1'b1);
            step(3);
            chk("actions", {4'h0, exp_bits(c)}, {4'h0, bits});
            chk("estop_current", c == 47 ? 16'h0123 : 16'h0000, cur);
            chk("decel_sel", c == 48 ? 16'h0003 : 16'h0000, {14'h0, dsel});
            chk("cmd_src", 16'h0000, {14'h0, csrc});
            sw.set_term(4, 6'(c), 1'b0);
            step(3);
            chk("released", 16'h0000, {4'h0, bits});
        end
        // walk all sixteen select patterns; entry 15 is past full scale
        for (int k = 0; k < 16; k++) begin
            for (int i = 0; i < 4; i++) sw.set_term(i, 6'h0C + 6'(i), k[i]);
            step(3);
            e = 16'(k * 70);
            chk("step_idx", 16'(k), {12'h000, sidx});
            chk("step_cmd", e, sc);
            chk("step_freq", e >= 16'h03E8 ? 16'h1388 : 16'(e * 5), sf);
        end
        // terminal source swapped to comm: keypad stop must be ignored
        src <= 2'h1;
        tq <= 1'b1;
        sw.set_term(4, 6'h25, 1'b1);
        sw.set_term(3, 6'h24, 1'b1);
        step(3);
        chk("swap_src", 16'h0002, {14'h0, csrc});
        chk("stop_ignored", 16'h0020, {4'h0, bits});
        sw.set_term(3, 6'h2E, 1'b1);
        step(3);
        chk("mode_flip", 16'h0000, {4'h0, bits});
        // keypad source is untouched by the swap terminal, so stop acts
        src <= 2'h0;
        tq <= 1'b0;
        sw.set_term(3, 6'h24, 1'b1);
        step(3);
        chk("keypad_src", 16'h0000, {14'h0, csrc});
        chk("keypad_stop", 16'h0400, {4'h0, bits});
        // gain swap ignored without the terminal condition; brake waits above start freq
        gbt <= 1'b0;
        ofreq <= 16'h0200;
        sw.set_term(3, 6'h2B, 1'b1);
        sw.set_term(4, 6'h31, 1'b1);
        step(3);
        chk("gain_off_brake_wait", 16'h0004, {4'h0, bits});
        test_done();
    end

    // watchdog: the sequence needs under two hundred cycles
    initial begin
        #400000;
        bad_count++;
        test_done();
    end
endmodule
